// ### pkg/ota_host_regs.svh
// Constants for the firmware-update sender: opcodes, framing sizes, CRC setup, timing.
// Assumes a 50 MHz core clock; included by bare name.
`ifndef OTA_HOST_REGS_SVH
`define OTA_HOST_REGS_SVH

`define OPC_LEGACY_START    16'hff01
`define OPC_EXT_BEGIN       16'hff07
`define OPC_END             16'hff02
`define RES_SUCCESS         8'h00
`define RES_LAST_VALID      8'h0e
`define FIRST_INDEX         16'h0001
`define UNIT_BYTES_LOG2     4
`define UNITS_DEFAULT       4'h1
`define UNITS_MAX           4'hf
`define PAD_BYTE            8'hff
`define CRC_INIT            16'hffff
`define CRC_POLY_REFL       16'ha001
`define CLK_PERIOD_NS       20
`define TICK_TIME_NS        1000
`define TICK_CYCLES         ((`TICK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_TICKS           8'h04

`endif

// ### pkg/ota_host_pkg.sv
// Types shared by the firmware-update sender and its helpers.
// Link framing is byte wide; the link layer below handles the radio.
package ota_host_pkg;

    typedef enum logic [1:0] {
        PKT_LEGACY_START,
        PKT_EXT_BEGIN,
        PKT_DATA,
        PKT_END
    } pkt_kind_type;

    typedef struct packed {
        logic       valid;
        logic       first;
        logic       last;
        logic       ack_req;
        logic [7:0] data;
    } link_tx_type;

    typedef struct packed {
        logic       valid;
        logic       is_write_rsp;
        logic       is_result;
        logic [7:0] code;
    } link_rx_type;

    typedef struct packed {
        logic       done;
        logic       link_abort;
        logic       bad_code;
        logic [7:0] code;
    } session_status_type;

endpackage

// ### design/crc16_step.sv
// One byte step of a reflected CRC-16.
// Purely combinational; the caller holds the running value.
`timescale 1ns/10ps
`default_nettype none
`include "ota_host_regs.svh"

module crc16_step (
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data,
    output logic      [15:0] crc_out
);

    always_comb begin
        logic [15:0] c;
        c = crc_in ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            if (c[0]) begin
                c = (c >> 1) ^ `CRC_POLY_REFL;
            end else begin
                c = c >> 1;
            end
        end
        crc_out = c;
    end

endmodule
`default_nettype wire

// ### design/pace_timer.sv
// Spacing timer: a divider makes a one-cycle tick, a counter waits a number of ticks.
// Runs on the single core clock; start restarts the wait.
`timescale 1ns/10ps
`default_nettype none
`include "ota_host_regs.svh"

module pace_timer #(
    parameter int          DIV   = `TICK_CYCLES,
    parameter logic [7:0]  TICKS = `GAP_TICKS
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      expired
);

    logic [15:0] div_r;
    logic        tick;
    logic [7:0]  left_r;

    assign tick = (div_r == 16'(DIV - 1));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 16'h0000;
        end else if (start || tick) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            left_r <= 8'h00;
        end else if (start) begin
            left_r <= TICKS;
        end else if (tick && left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end
    end

    assign expired = (left_r == 8'h00) && !start;

endmodule
`default_nettype wire

// ### design/ota_update_sender.sv
// Master-side firmware-update sender: frames start, data and end attribute values
// and reacts to the peer's write responses and single result message.
// Assumes a link layer that carries each frame as one attribute write.
`timescale 1ns/10ps
`default_nettype none
`include "ota_host_regs.svh"

module ota_update_sender
    import ota_host_pkg::*;
#(
    parameter int         DIV       = `TICK_CYCLES,
    parameter logic [7:0] GAP_TICKS = `GAP_TICKS
) (
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    input  wire logic               go,
    input  wire logic               extended_mode,
    input  wire logic [3:0]         payload_units,
    input  wire logic               ack_mode,
    input  wire logic               negotiated,
    input  wire logic               link_up,
    input  wire logic               img_valid,
    input  wire logic [7:0]         img_data,
    input  wire logic               img_last,
    output logic                    img_ready,
    output link_tx_type             link_tx,
    input  wire logic               link_tx_ready,
    input  wire link_rx_type        link_rx,
    output logic                    busy,
    output logic                    cfg_reject,
    output session_status_type      status
);

    typedef enum logic [2:0] {
        S_IDLE,
        S_WAIT_NEG,
        S_SEND,
        S_WAIT_ACK,
        S_GAP,
        S_WAIT_RESULT
    } state_type;

    logic               rst_s1_r;
    logic               rst_n;
    state_type          st_r;
    pkt_kind_type       kind_r;
    logic [7:0]         pos_r;
    logic [7:0]         len_r;
    logic [15:0]        idx_r;
    logic [15:0]        crc_r;
    logic [15:0]        crc_nxt;
    logic               ack_r;
    logic [7:0]         hold_r;
    logic               hold_v_r;
    logic               hold_last_r;
    logic               img_ended_r;
    link_tx_type        tx_r;
    logic               busy_r;
    logic               img_ready_r;
    logic               cfg_reject_r;
    session_status_type status_r;
    logic               gap_start;
    logic               gap_done;
    logic [7:0]         last_pos;
    logic [7:0]         byte_nxt;
    logic               in_payload;
    logic               byte_ok;
    logic               emit;
    logic               consume;
    logic               pkt_done;
    logic               cfg_ok;
    logic               result_in;
    logic               abort;

    // Opcodes as sized constants so single bytes can be selected from them
    localparam logic [15:0] op_legacy = `OPC_LEGACY_START;
    localparam logic [15:0] op_begin  = `OPC_EXT_BEGIN;
    localparam logic [15:0] op_end    = `OPC_END;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // Legacy flow keeps the default payload; extended flow needs 1..15 units of 16
    assign cfg_ok = !extended_mode ||
                    (payload_units != 4'h0 && payload_units <= `UNITS_MAX);

    assign in_payload = (kind_r == PKT_DATA) && (pos_r >= 8'h02) && (pos_r < len_r + 8'h02);

    always_comb begin
        case (kind_r)
            PKT_LEGACY_START: last_pos = 8'h01;
            PKT_EXT_BEGIN:    last_pos = 8'h03;
            PKT_END:          last_pos = 8'h05;
            default:          last_pos = len_r + 8'h03;
        endcase
    end

    always_comb begin
        byte_nxt = 8'h00;
        case (kind_r)
            PKT_LEGACY_START: begin
                byte_nxt = (pos_r == 8'h00) ? op_legacy[7:0] : op_legacy[15:8];
            end
            PKT_EXT_BEGIN: begin
                if (pos_r == 8'h00) begin
                    byte_nxt = op_begin[7:0];
                end else if (pos_r == 8'h01) begin
                    byte_nxt = op_begin[15:8];
                end else if (pos_r == 8'h02) begin
                    byte_nxt = len_r;
                end else begin
                    byte_nxt = 8'h00;
                end
            end
            PKT_END: begin
                // Highest index used, then its inverted check copy
                if (pos_r == 8'h00) begin
                    byte_nxt = op_end[7:0];
                end else if (pos_r == 8'h01) begin
                    byte_nxt = op_end[15:8];
                end else if (pos_r == 8'h02) begin
                    byte_nxt = idx_r[7:0];
                end else if (pos_r == 8'h03) begin
                    byte_nxt = idx_r[15:8];
                end else if (pos_r == 8'h04) begin
                    byte_nxt = ~idx_r[7:0];
                end else begin
                    byte_nxt = ~idx_r[15:8];
                end
            end
            default: begin
                if (pos_r == 8'h00) begin
                    byte_nxt = idx_r[7:0];
                end else if (pos_r == 8'h01) begin
                    byte_nxt = idx_r[15:8];
                end else if (in_payload) begin
                    byte_nxt = img_ended_r ? `PAD_BYTE : hold_r;
                end else if (pos_r == last_pos) begin
                    byte_nxt = crc_r[15:8];
                end else begin
                    byte_nxt = crc_r[7:0];
                end
            end
        endcase
    end

    assign byte_ok  = !(in_payload && !img_ended_r && !hold_v_r);
    assign emit     = (st_r == S_SEND) && byte_ok && (!tx_r.valid || link_tx_ready) && !abort;
    assign consume  = emit && in_payload && !img_ended_r;
    assign pkt_done = emit && (pos_r == last_pos);

    assign result_in = link_rx.valid && link_rx.is_result && busy_r;
    assign abort     = busy_r && (!link_up || result_in);

    crc16_step u_crc (
        .crc_in  (crc_r),
        .data    (byte_nxt),
        .crc_out (crc_nxt)
    );

    pace_timer #(
        .DIV   (DIV),
        .TICKS (GAP_TICKS)
    ) u_gap (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .start    (gap_start),
        .expired  (gap_done)
    );

    assign gap_start = (pkt_done && !ack_r && kind_r != PKT_END) ||
                       (st_r == S_WAIT_ACK && link_rx.valid && link_rx.is_write_rsp);

    // Session sequencing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r   <= S_IDLE;
            kind_r <= PKT_LEGACY_START;
            pos_r  <= 8'h00;
            len_r  <= 8'h10;
            idx_r  <= `FIRST_INDEX;
            ack_r  <= 1'b0;
        end else if (abort) begin
            st_r <= S_IDLE;
        end else begin
            case (st_r)
                S_IDLE: begin
                    if (go && cfg_ok) begin
                        ack_r <= ack_mode;
                        pos_r <= 8'h00;
                        idx_r <= `FIRST_INDEX;
                        len_r <= extended_mode ? {payload_units, 4'h0}
                                               : {`UNITS_DEFAULT, 4'h0};
                        kind_r <= extended_mode ? PKT_EXT_BEGIN : PKT_LEGACY_START;
                        st_r   <= extended_mode ? S_WAIT_NEG : S_SEND;
                    end
                end
                S_WAIT_NEG: begin
                    if (negotiated) begin
                        st_r <= S_SEND;
                    end
                end
                S_SEND: begin
                    if (emit) begin
                        pos_r <= pos_r + 8'h01;
                    end
                    if (pkt_done) begin
                        pos_r <= 8'h00;
                        if (kind_r == PKT_END) begin
                            st_r <= S_WAIT_RESULT;
                        end else begin
                            st_r <= ack_r ? S_WAIT_ACK : S_GAP;
                        end
                    end
                end
                S_WAIT_ACK: begin
                    if (link_rx.valid && link_rx.is_write_rsp) begin
                        st_r <= S_GAP;
                    end
                end
                S_GAP: begin
                    if (gap_done) begin
                        st_r <= S_SEND;
                        if (kind_r == PKT_DATA && img_ended_r) begin
                            kind_r <= PKT_END;
                        end else if (kind_r == PKT_DATA) begin
                            idx_r <= idx_r + 16'h0001;
                        end else begin
                            kind_r <= PKT_DATA;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Running CRC over index and payload only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_r <= `CRC_INIT;
        end else if (st_r != S_SEND) begin
            crc_r <= `CRC_INIT;
        end else if (emit && kind_r == PKT_DATA && pos_r < len_r + 8'h02) begin
            crc_r <= crc_nxt;
        end
    end

    // Image intake: one-byte hold keeps img_ready registered at one byte per three cycles at most
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r      <= 8'h00;
            hold_v_r    <= 1'b0;
            hold_last_r <= 1'b0;
            img_ready_r <= 1'b0;
            img_ended_r <= 1'b0;
        end else if (!busy_r || abort) begin
            hold_v_r    <= 1'b0;
            img_ready_r <= 1'b0;
            img_ended_r <= 1'b0;
        end else begin
            if (img_ready_r && img_valid) begin
                hold_r      <= img_data;
                hold_v_r    <= 1'b1;
                hold_last_r <= img_last;
                img_ready_r <= 1'b0;
            end else if (consume) begin
                hold_v_r    <= 1'b0;
                img_ended_r <= hold_last_r;
            end else begin
                img_ready_r <= !hold_v_r && !img_ended_r;
            end
        end
    end

    // Link byte register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_r <= '0;
        end else if (emit) begin
            tx_r.valid   <= 1'b1;
            tx_r.first   <= (pos_r == 8'h00);
            tx_r.last    <= (pos_r == last_pos);
            tx_r.ack_req <= ack_r;
            tx_r.data    <= byte_nxt;
        end else if (link_tx_ready || abort) begin
            tx_r.valid <= 1'b0;
        end
    end

    // Session status: the one result message closes the session
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r       <= 1'b0;
            cfg_reject_r <= 1'b0;
            status_r     <= '0;
        end else begin
            cfg_reject_r  <= !busy_r && go && !cfg_ok;
            status_r.done <= 1'b0;
            if (!busy_r && go && cfg_ok) begin
                busy_r   <= 1'b1;
                status_r <= '0;
            end else if (abort) begin
                busy_r              <= 1'b0;
                status_r.done       <= 1'b1;
                status_r.link_abort <= !link_up;
                status_r.code       <= result_in ? link_rx.code : 8'h00;
                status_r.bad_code   <= result_in && (link_rx.code > `RES_LAST_VALID);
            end
        end
    end

    assign img_ready  = img_ready_r;
    assign link_tx    = tx_r;
    assign busy       = busy_r;
    assign cfg_reject = cfg_reject_r;
    assign status     = status_r;

endmodule
`default_nettype wire

// ### test/ota_update_sender_properties.sv
// Port checker for the update sender, bound to every instance.
// Assumes one core clock domain and the active-low reset at the top port.
`timescale 1ns/10ps
`default_nettype none
module ota_update_sender_props
    import ota_host_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    input  wire logic               go,
    input  wire logic               extended_mode,
    input  wire logic [3:0]         payload_units,
    input  wire logic               negotiated,
    input  wire logic               link_up,
    input  wire link_tx_type        link_tx,
    input  wire logic               link_tx_ready,
    input  wire link_rx_type        link_rx,
    input  wire logic               busy,
    input  wire logic               cfg_reject,
    input  wire session_status_type status
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_halt;
        link_rx.valid && link_rx.is_result && busy && link_rx.code <= 8'h0e
        |=> !busy && status.done && status.code == $past(link_rx.code);
    endproperty
    a_halt: assert property (p_halt) else $error("session did not end on result");
    property p_quiet;
        !busy && !$past(busy) |-> !link_tx.valid;
    endproperty
    a_quiet: assert property (p_quiet) else $error("link byte offered while idle");
    property p_hold;
        link_tx.valid && !link_tx_ready && link_up && busy && !(link_rx.valid && link_rx.is_result) |=> $stable(link_tx);
    endproperty
    a_hold: assert property (p_hold) else $error("link byte changed before taken");
    property p_leg;
        $rose(busy) && !extended_mode |=> link_tx.valid && link_tx.first && link_tx.data == 8'h01;
    endproperty
    a_leg: assert property (p_leg) else $error("legacy start not sent first");
    property p_neg;
        busy && extended_mode && !negotiated |-> !link_tx.valid;
    endproperty
    a_neg: assert property (p_neg) else $error("sent before negotiation");
    property p_rej;
        go && !busy && extended_mode && payload_units == 4'h0 |=> cfg_reject && !busy;
    endproperty
    a_rej: assert property (p_rej) else $error("bad payload size not refused");
    property p_rej_pulse;
        cfg_reject |=> !cfg_reject;
    endproperty
    a_rej_pulse: assert property (p_rej_pulse) else $error("refusal longer than one cycle");
    property p_abort;
        busy && !link_up |-> ##[1:4] !busy && status.link_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("link loss did not stop session");
    property p_bad;
        link_rx.valid && link_rx.is_result && busy && link_rx.code > 8'h0e |=> status.bad_code;
    endproperty
    a_bad: assert property (p_bad) else $error("reserved result code not flagged");
    property p_done;
        status.done |=> !status.done;
    endproperty
    a_done: assert property (p_done) else $error("done longer than one cycle");
endmodule

bind ota_update_sender ota_update_sender_props u_props (
    .core_clk(core_clk), .rst_b(rst_b), .go(go), .extended_mode(extended_mode),
    .payload_units(payload_units), .negotiated(negotiated), .link_up(link_up), .link_tx(link_tx),
    .link_tx_ready(link_tx_ready), .link_rx(link_rx), .busy(busy), .cfg_reject(cfg_reject), .status(status)
);
`default_nettype wire

// ### test/ota_device_model.sv
// Behavioural update receiver on the far side of the link.
// Assumes bench-driven stall, answer delay and fault injection inputs.
`timescale 1ns/10ps
`default_nettype none
module ota_device_model
    import ota_host_pkg::*;
#(
    parameter int GAP_MAX = 5000,
    parameter int SES_MAX = 60000
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire link_tx_type link_tx,
    input  wire logic        hold,
    input  wire logic [3:0]  dly,
    input  wire logic [7:0]  inj_code,
    input  wire logic [7:0]  inj_frame,
    output logic             link_tx_ready,
    output var link_rx_type  link_rx
);
    logic [7:0]  fb[0:255];
    logic [7:0]  img[0:4095];
    int          n, frames, plen, nidx, gap_c, ses_c, w;
    logic        started, ended;
    link_rx_type q[$];

    assign link_tx_ready = !hold;

    function automatic logic [15:0] crc(input int len);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 0; i < len; i++) begin
            c ^= {8'h00, fb[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction

    task automatic result(input logic [7:0] code);
        if (!ended)
            q.push_back('{1'b1, 1'b0, 1'b1, code});
        ended = 1'b1;
    endtask

    task automatic frame();
        logic [15:0] op;
        op = {fb[1], fb[0]};
        frames++;
        gap_c = 0;
        if (op == 16'hff01 || op == 16'hff07) begin
            started = 1'b1;
            ended = 1'b0;
            frames = 0;
            nidx = 1;
            ses_c = 0;
            plen = (op == 16'hff07) ? int'(fb[2]) : 16;
        end else if (frames == inj_frame) result(inj_code);
        else if (!started) result(8'h02);
        else if (op == 16'hff02)
            result(n == 6 && {fb[3], fb[2]} == ~{fb[5], fb[4]} && {fb[3], fb[2]} == 16'(nidx - 1) ? 8'h00 : 8'h05);
        else if (n != plen + 4) result(8'h09);
        else if (op != nidx) result(op * plen > 4096 ? 8'h02 : 8'h01);
        else if (crc(n - 2) != {fb[n-1], fb[n-2]}) result(8'h03);
        else begin
            for (int i = 0; i < plen; i++) img[(nidx - 1) * plen + i] = fb[i + 2];
            nidx++;
        end
    endtask

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            n = 0;
            started = 1'b0;
            ended = 1'b0;
            q.delete();
            link_rx <= '0;
        end else begin
            // Idle fields keep changing so a stale code is never mistaken for a fresh one
            link_rx <= '{1'b0, 1'b0, 1'b0, ~link_rx.code};
            if (link_tx.valid && link_tx_ready) begin
                if (link_tx.first)
                    n = 0;
                if (n < 256)
                    fb[n] = link_tx.data;
                n++;
                if (link_tx.last) begin
                    if (link_tx.ack_req)
                        q.push_back('{1'b1, 1'b1, 1'b0, 8'h00});
                    frame();
                end
            end
            if (started && !ended) begin
                gap_c++;
                ses_c++;
                if (gap_c == GAP_MAX) result(8'h0c);
                if (ses_c == SES_MAX) result(8'h0d);
            end
            if (q.size() == 0) w = dly;
            else if (w > 0) w--;
            else begin
                link_rx <= q.pop_front();
                w = dly;
            end
        end
    end
endmodule
`default_nettype wire

// ### test/tb_ota_update_sender.sv
// Self-checking bench: update sender against the behavioural receiver.
// Assumes shortened pacing (DIV 2, one gap tick) and one 50 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb_ota_update_sender
    import ota_host_pkg::*;
;
    logic               core_clk, rst_b = 1'b0, go = 1'b0, extended_mode = 1'b0, ack_mode = 1'b0;
    logic               negotiated = 1'b0, link_up = 1'b0, img_valid = 1'b0, img_last = 1'b0, hold = 1'b0;
    logic               img_ready, link_tx_ready, busy, cfg_reject, src_on = 1'b0, slow = 1'b0, seen_done;
    logic [3:0]         payload_units = 4'h0, dly = 4'h0;
    logic [7:0]         img_data = 8'h00, inj_code = 8'h00, inj_frame = 8'h00;
    logic [7:0]         src[0:4095];
    logic [7:0]         codes[8] = '{8'h01, 8'h03, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'hff};
    logic [31:0]        seed = 32'h2d42, r;
    link_tx_type        link_tx;
    link_rx_type        link_rx;
    session_status_type status;
    int                 n_fail = 0, n_checks = 0, n_src = 0, ip = 0, cyc = 0;

    ota_update_sender #(.DIV(2), .GAP_TICKS(8'h01)) uut (
        .core_clk(core_clk), .rst_b(rst_b), .go(go), .extended_mode(extended_mode),
        .payload_units(payload_units), .ack_mode(ack_mode), .negotiated(negotiated), .link_up(link_up),
        .img_valid(img_valid), .img_data(img_data), .img_last(img_last), .img_ready(img_ready),
        .link_tx(link_tx), .link_tx_ready(link_tx_ready), .link_rx(link_rx), .busy(busy),
        .cfg_reject(cfg_reject), .status(status));
    ota_device_model dev (
        .core_clk(core_clk), .rst_b(rst_b), .link_tx(link_tx), .hold(hold), .dly(dly),
        .inj_code(inj_code), .inj_frame(inj_frame), .link_tx_ready(link_tx_ready), .link_rx(link_rx));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Cycle ceiling well above the longest expected run; a hang fails the run
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            end_sim();
        end
    end

    // Source keeps a byte offered until taken; stalls come from the link side only
    always @(posedge core_clk) begin
        if (img_valid && img_ready)
            ip++;
        #1;
        r = rnd();
        if (status.done)
            seen_done = 1'b1;
        hold = slow && r[0];
        dly = slow ? r[4:1] & 4'h7 : 4'h0;
        img_valid = src_on && ip < n_src;
        img_data = src[ip];
        img_last = ip == n_src - 1;
    end

    task automatic run(input logic ext, input logic [3:0] units, input logic ack, input int n,
                       input logic [7:0] code, input logic [7:0] frm, input int cut);
        int plen, t;
        plen = ext ? int'(units) * 16 : 16;
        for (int i = 0; i < 4096; i++) dev.img[i] = 8'h5a;
        for (int i = 0; i < n; i++) src[i] = 8'(rnd());
        n_src = n;
        ip = 0;
        inj_code = code;
        inj_frame = frm;
        seen_done = 1'b0;
        extended_mode = ext;
        payload_units = units;
        ack_mode = ack;
        negotiated = !ext;
        link_up = 1'b1;
        src_on = 1'b1;
        go = 1'b1;
        @(posedge core_clk);
        #1 go = 1'b0;
        if (ext) begin
            repeat (5) @(posedge core_clk);
            #1 negotiated = 1'b1;
        end
        t = 0;
        while (busy === 1'b1) begin
            @(posedge core_clk);
            #1 t++;
            if (t == cut)
                link_up = 1'b0;
        end
        repeat (2) @(posedge core_clk);
        #1 src_on = 1'b0;
        if (cut > 0)
            check8({7'h0, status.link_abort}, 8'h01);
        else begin
            check8({7'h0, seen_done}, 8'h01);
            check8({7'h0, status.bad_code}, {7'h0, code > 8'h0e});
            if (code <= 8'h0e)
                check8(status.code, code);
            if (code == 8'h00)
                for (int i = 0; i < (n + plen - 1) / plen * plen; i++)
                    check8(dev.img[i], i < n ? src[i] : 8'hff);
        end
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        run(1'b0, 4'h0, 1'b0, 37, 8'h00, 8'h00, 0);
        slow = 1'b1;
        run(1'b1, 4'h3, 1'b1, 100, 8'h00, 8'h00, 0);
        run(1'b1, 4'hf, 1'b0, 241, 8'h00, 8'h00, 0);
        run(1'b1, 4'h1, 1'b1, 16, 8'h00, 8'h00, 0);
        for (int i = 0; i < 8; i++)
            run(1'b0, 4'h0, i[0], 60, codes[i], 8'h02, 0);
        for (int i = 0; i < 4; i++) begin
            logic [31:0] pick;
            pick = rnd();
            run(pick[0], (pick[4:1] == 4'h0) ? 4'h1 : pick[4:1], pick[5], int'(pick[14:6]) + 1,
                8'h00, 8'h00, 0);
        end
        run(1'b0, 4'h0, 1'b0, 200, 8'h00, 8'h00, 30);
        extended_mode = 1'b1;
        payload_units = 4'h0;
        go = 1'b1;
        @(posedge core_clk);
        #1 go = 1'b0;
        check8({6'h0, cfg_reject, busy}, 8'h02);
        repeat (3) @(posedge core_clk);
        end_sim();
    end
endmodule
`default_nettype wire
